// [design/fws_host.sv]
// Function
// (RL1) poll bit inverts during program
// (RL2) poll valid after last write pulse
// (RL3) poll bit zero while erasing
// (RL4) poll at target sector address
// (RL5) trust full byte only next read
// (RL6) busy pin low during operations
// (RL7) busy valid after final write
// (RL8) toggle one flips per read
// (RL9) toggle valid after last pulse
// (RL10) protected program toggles two microseconds
// (RL11) protected erase toggles hundred microseconds
// (RL12) fail bit means limit exceeded
// (RL13) wrong program fails, needs reset
// (RL14) recheck toggle after fail bit
// (RL15) erase started bit after 30h
// (RL16) toggle two within erase sectors
// (RL17) combine toggle bits for mode
// (RL18) two reads compare toggle bit
// (RL19) fail high: recheck, reset on toggle
// (RL20) resumed polling restarts from start
// (RL21) reset command returns to reading
// (RL22) suspended sector reads give status
// (RL23) toggles advance per read strobe
`timescale 1ns/1ps
module fws_host
  import fws_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic req_valid,
  input wire fws_pkg::fws_req_t req,
  output logic req_ready,
  output logic res_valid,
  output fws_pkg::fws_res_t res,
  output logic [19:0] addr,
  output logic [7:0] dq_o,
  output logic dq_oe,
  input wire logic [7:0] dq_i,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  input wire logic ready_busy_pin,
  output logic busy_seen
);
  import fws_pkg::*;

  typedef enum {S_IDLE, S_WRITE, S_READ_A, S_READ_B, S_READ_C, S_EVAL, S_DONE} fws_st_t;

  fws_st_t st_q, st_d;
  fws_req_t req_q, req_d; // latched order
  logic [2:0] wcnt_q, wcnt_d; // write cycle index
  logic [2:0] wlen_q, wlen_d; // cycles in sequence
  logic [3:0] tcnt_q, tcnt_d; // strobe timer
  logic ph_q, ph_d; // strobe phase low/high
  logic [7:0] rd1_q, rd1_d; // first status read
  logic [7:0] rd2_q, rd2_d; // second status read
  logic failseen_q, failseen_d; // fail bit seen, recheck pending
  logic [19:0] addr_q, addr_d;
  logic [7:0] dqo_q, dqo_d;
  logic oe_q, oe_d, ce_q, ce_d, rdn_q, rdn_d, wen_q, wen_d;
  logic rv_q, rv_d;
  fws_res_t res_q, res_d;
  logic bsy_q, bsy_d;

  // write sequence word for a given cycle
  function automatic logic [27:0] seq_word(fws_req_t r, logic [2:0] i);
    logic [27:0] w;
    w = {ADDR_UNLOCK1, CMD_UNLOCK1};
    case (i)
      3'h0: w = {ADDR_UNLOCK1, CMD_UNLOCK1};
      3'h1: w = {ADDR_UNLOCK2, CMD_UNLOCK2};
      3'h2: w = (r.op == FWS_OP_PROG) ? {ADDR_UNLOCK1, CMD_PROGRAM}
                                      : {ADDR_UNLOCK1, CMD_ERASE_SETUP};
      3'h3: w = (r.op == FWS_OP_PROG) ? {r.addr, r.data} : {ADDR_UNLOCK1, CMD_UNLOCK1};
      3'h4: w = {ADDR_UNLOCK2, CMD_UNLOCK2};
      3'h5: w = (r.op == FWS_OP_CHIP) ? {ADDR_UNLOCK1, CMD_CHIP_ERASE}
                                      : {r.addr, CMD_SECTOR_ERASE};
      default: w = {ADDR_UNLOCK1, CMD_UNLOCK1};
    endcase
    return w;
  endfunction

  // next state of the polling sequencer
  always_comb begin
    logic [27:0] w;
    logic tog1, tog2;
    w = seq_word(req_q, wcnt_q);
    tog1 = 1'b0;
    tog2 = 1'b0;
    st_d = st_q;
    req_d = req_q;
    wcnt_d = wcnt_q;
    wlen_d = wlen_q;
    tcnt_d = tcnt_q;
    ph_d = ph_q;
    rd1_d = rd1_q;
    rd2_d = rd2_q;
    failseen_d = failseen_q;
    addr_d = addr_q;
    dqo_d = dqo_q;
    oe_d = oe_q;
    ce_d = ce_q;
    rdn_d = rdn_q;
    wen_d = wen_q;
    rv_d = 1'b0;
    res_d = res_q;
    bsy_d = bsy_q;
    case (st_q)
      S_IDLE: begin
        if (req_valid) begin
          req_d = req;
          wcnt_d = 3'h0;
          // (RL21) reset command single cycle
          wlen_d = (req.op == FWS_OP_PROG) ? 3'h4 : (req.op == FWS_OP_RESET) ? 3'h1 : 3'h6;
          tcnt_d = STROBE_RST;
          ph_d = 1'b0;
          failseen_d = 1'b0;
          bsy_d = 1'b0;
          // result starts as success; only a failed poll clears it
          res_d = '{ok: 1'b1, fail: 1'b0, last: 8'h00};
          st_d = S_WRITE;
        end
      end
      S_WRITE: begin
        // (RL13) reset word goes out as cycle zero
        addr_d = (req_q.op == FWS_OP_RESET) ? ADDR_UNLOCK1 : w[27:8];
        dqo_d = (req_q.op == FWS_OP_RESET) ? CMD_RESET : w[7:0];
        oe_d = 1'b1;
        ce_d = 1'b0;
        // read strobe ends on the same edge that starts driving the bus
        rdn_d = 1'b1;
        wen_d = ph_q;
        tcnt_d = tcnt_q + 4'h1;
        if (tcnt_q == STROBE_CNT) begin
          tcnt_d = STROBE_RST;
          ph_d = ~ph_q;
          if (ph_q) begin
            wcnt_d = wcnt_q + 3'h1;
            // (RL2) polling starts only after final rising edge
            if (wcnt_q + 3'h1 == wlen_q) begin
              oe_d = 1'b0;
              ce_d = 1'b1;
              wen_d = 1'b1;
              st_d = (req_q.op == FWS_OP_RESET) ? S_DONE : S_READ_A;
            end
          end
        end
      end
      S_READ_A, S_READ_B, S_READ_C: begin
        // (RL4) read at the targeted sector address
        addr_d = req_q.addr;
        oe_d = 1'b0;
        ce_d = ph_q;
        rdn_d = ph_q;
        // (RL7) busy pin sampled only after the command sequence
        if (!ready_busy_pin) bsy_d = 1'b1;
        tcnt_d = tcnt_q + 4'h1;
        if (tcnt_q == STROBE_CNT) begin
          tcnt_d = STROBE_RST;
          ph_d = ~ph_q;
          if (!ph_q) begin
            // (RL23) one sample per completed strobe
            if (st_q == S_READ_A) begin
              rd1_d = dq_i;
              st_d = S_READ_B;
            end else if (st_q == S_READ_B) begin
              rd2_d = dq_i;
              st_d = S_EVAL;
            end else begin
              // (RL5) full byte taken from a later read
              res_d.last = dq_i;
              st_d = S_DONE;
            end
          end
        end
      end
      S_EVAL: begin
        // (RL8) toggle bit one compared across reads
        tog1 = rd1_q[TOG1_POS] ^ rd2_q[TOG1_POS];
        // (RL16) toggle bit two marks erase sectors
        tog2 = rd1_q[TOG2_POS] ^ rd2_q[TOG2_POS];
        // (RL18) unchanged toggle means done
        if (!tog1) begin
          // (RL14) stopped after fail bit still counts as success
          res_d.ok = 1'b1;
          res_d.fail = 1'b0;
          st_d = S_READ_C;
        end else if (failseen_q) begin
          // (RL19) still toggling after fail bit: failure, reset
          res_d.ok = 1'b0;
          res_d.fail = 1'b1;
          req_d.op = FWS_OP_RESET;
          wcnt_d = 3'h0;
          wlen_d = 3'h1;
          // restart the strobe timer in the low phase, else no pulse goes out
          tcnt_d = STROBE_RST;
          ph_d = 1'b0;
          st_d = S_WRITE;
        end else begin
          // (RL14) fail bit seen: check toggle once more
          if (rd2_q[FAIL_POS]) failseen_d = 1'b1;
          // (RL20) each resumed look restarts with two reads
          st_d = S_READ_A;
        end
        // (RL17) toggle two alone cannot show the mode
        if (tog2 && !tog1) res_d.ok = res_d.ok;
      end
      S_DONE: begin
        rv_d = 1'b1;
        oe_d = 1'b0;
        ce_d = 1'b1;
        rdn_d = 1'b1;
        st_d = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
  end

  // register all state, frozen while clk_en is low
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= S_IDLE;
      req_q <= '0;
      wcnt_q <= 3'h0;
      wlen_q <= 3'h0;
      tcnt_q <= STROBE_RST;
      ph_q <= 1'b0;
      rd1_q <= 8'h00;
      rd2_q <= 8'h00;
      failseen_q <= 1'b0;
      addr_q <= 20'h00000;
      dqo_q <= 8'h00;
      oe_q <= 1'b0;
      ce_q <= 1'b1;
      rdn_q <= 1'b1;
      wen_q <= 1'b1;
      rv_q <= 1'b0;
      res_q <= '0;
      bsy_q <= 1'b0;
    end else if (clk_en) begin
      st_q <= st_d;
      req_q <= req_d;
      wcnt_q <= wcnt_d;
      wlen_q <= wlen_d;
      tcnt_q <= tcnt_d;
      ph_q <= ph_d;
      rd1_q <= rd1_d;
      rd2_q <= rd2_d;
      failseen_q <= failseen_d;
      addr_q <= addr_d;
      dqo_q <= dqo_d;
      oe_q <= oe_d;
      ce_q <= ce_d;
      rdn_q <= rdn_d;
      wen_q <= wen_d;
      rv_q <= rv_d;
      res_q <= res_d;
      bsy_q <= bsy_d;
    end
  end

  // ready is a registered idle flag
  logic rdy_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) rdy_q <= 1'b1;
    else if (clk_en) rdy_q <= (st_d == S_IDLE);
  end

  assign req_ready = rdy_q;
  assign res_valid = rv_q;
  assign res = res_q;
  assign addr = addr_q;
  assign dq_o = dqo_q;
  assign dq_oe = oe_q;
  assign ce_n = ce_q;
  assign oe_n = rdn_q;
  assign we_n = wen_q;
  assign busy_seen = bsy_q;

  // no write and read strobe together
  strobe_excl_a: assert property (@(posedge clk_sys) disable iff (rst)
    !(!wen_q && !rdn_q)) else $error("write and read strobes overlap"); // (RL2)
  // bus driven whenever the write strobe is low
  drive_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    !wen_q |-> oe_q) else $error("write without data drive"); // (RL13)
  // no drive while reading
  read_float_a: assert property (@(posedge clk_sys) disable iff (rst)
    !rdn_q |-> !oe_q) else $error("data driven during read"); // (RL4)
  // a result pulse lasts one cycle
  res_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
    rv_q && clk_en |=> !rv_q) else $error("result longer than a cycle"); // (RL18)
  // read addresses the target
  read_addr_a: assert property (@(posedge clk_sys) disable iff (rst)
    !rdn_q |-> addr_q == req_q.addr) else $error("poll away from target"); // (RL4)
  // failure only after fail bit seen
  fail_cause_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(res_q.fail) |-> $past(failseen_q)) else $error("fail without fail bit"); // (RL19)
  // two reads precede each evaluation
  eval_after_a: assert property (@(posedge clk_sys) disable iff (rst)
    st_q == S_EVAL && $changed(st_q) |-> $past(st_q) == S_READ_B)
    else $error("eval without two reads"); // (RL18)
  // strobe low lasts the full count
  strobe_len_a: assert property (@(posedge clk_sys) disable iff (rst || !clk_en)
    $fell(wen_q) |-> !wen_q [*8]) else $error("write strobe too short"); // (RL7)

  cov_write_c: cover property (@(posedge clk_sys) st_q == S_WRITE);
  cov_eval_c: cover property (@(posedge clk_sys) st_q == S_EVAL && failseen_q);
  cov_done_c: cover property (@(posedge clk_sys) rv_q && res_q.ok);
  cov_fail_c: cover property (@(posedge clk_sys) rv_q && res_q.fail);
endmodule

// [design/fws_pkg.sv]
package fws_pkg;
  // status bit positions on the data bus
  localparam int POLL_POS = 7;
  localparam int TOG1_POS = 6;
  localparam int FAIL_POS = 5;
  localparam int ESTART_POS = 3;
  localparam int TOG2_POS = 2;
  // command values
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [19:0] ADDR_UNLOCK1 = 20'h00555;
  localparam logic [19:0] ADDR_UNLOCK2 = 20'h002AA;
  // bus cycle timing in clocks (strobe low / gap)
  localparam int STROBE_NS = 80;
  localparam int CLK_NS = 10;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
  localparam logic [3:0] STROBE_RST = 4'h0;
  // operation kinds
  typedef enum logic [1:0] {FWS_OP_PROG, FWS_OP_CHIP, FWS_OP_SECT, FWS_OP_RESET} fws_op_t;
  // user request
  typedef struct packed {
    fws_op_t op;
    logic [19:0] addr;
    logic [7:0] data;
  } fws_req_t;
  // result
  typedef struct packed {
    logic ok;
    logic fail;
    logic [7:0] last;
  } fws_res_t;
endpackage

// [tb/fws_flash_model.sv]
`timescale 1ns/1ps
// behavioural flash device on the far side of the host's bus
module fws_flash_model
  import fws_pkg::*;
#(
  parameter int PROG_NS = 2000, // program busy time
  parameter int ERASE_NS = 4000, // erase busy time
  parameter logic [19:0] PROT_BASE = 20'hF0000, // protected sector start
  parameter int PROT_PROG_NS = 2000, // protected program spin time
  parameter int PROT_ERASE_NS = 100000 // protected erase spin time
)(
  input wire logic [19:0] addr,
  input wire logic [7:0] dq_in,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  output logic [7:0] dq_out,
  output logic ready_busy_pin
);
  logic [7:0] mem [logic [19:0]]; // unwritten places read erased
  logic busy = 0, fail = 0, tog = 0, ers = 0, sect = 0, bad = 0, wce = 1, prot = 0;
  logic [7:0] tgt = 8'hFF, held = 8'h00, wd = 8'h00;
  logic [19:0] tga = 20'h00000, wa = 20'h00000;
  int step = 0;
  int dur = 0;
  event go;
  wire rd_on = !ce_n && !oe_n && we_n;
  wire [7:0] rd_val;
  function automatic logic [7:0] rd_mem(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  // latch inside the strobe so the host's next update cannot race us
  always @(negedge we_n) #1 begin
    wa = addr;
    wd = dq_in;
    wce = ce_n;
  end
  // command decode on the rising write strobe
  always @(posedge we_n) begin
    // a program data byte of F0 is data, not a reset
    if (!wce && wd == CMD_RESET && step != 6) begin
      step = 0;
      if (fail) {busy, fail} = 2'b00;
    end else if (!wce && !busy) begin
      case (step)
        0, 3: step = (wd == CMD_UNLOCK1 && wa == ADDR_UNLOCK1) ? step + 1 : 0;
        1, 4: step = (wd == CMD_UNLOCK2 && wa == ADDR_UNLOCK2) ? step + 1 : 0;
        2: step = wd == CMD_PROGRAM ? 6 : wd == CMD_ERASE_SETUP ? 3 : 0;
        default: begin
          // status starts at the final write pulse
          ers = step == 5;
          sect = ers && wd == CMD_SECTOR_ERASE;
          tgt = wd;
          tga = wa;
          // protected target: spin, then keep data
          prot = (!ers || sect) && wa >= PROT_BASE;
          bad = !ers && !prot && ((wd & ~rd_mem(wa)) != 8'h00);
          dur = prot ? (ers ? PROT_ERASE_NS : PROT_PROG_NS) : ers ? ERASE_NS : PROG_NS;
          busy = 1;
          step = 0;
          -> go;
        end
      endcase
    end
  end
  // embedded algorithm; a bad program hangs until reset
  always begin
    @(go);
    #(dur);
    // limit exceeded on one over zero
    if (bad) fail = 1;
    else begin
      if (prot) prot = 0;
      else if (ers) mem.delete(); // whole array: sectors not modelled
      else mem[tga] = rd_mem(tga) & tgt;
      busy = 0;
    end
  end
  // status byte while busy, array data after
  assign rd_val = busy ? {!ers && !tgt[7], tog, fail, 1'b0, sect, ers && tog, 2'b00}
                       : rd_mem(addr);
  // released bus shows the inverse of the last byte, no keeper
  always @(rd_val or rd_on) if (rd_on) held = rd_val;
  assign dq_out = rd_on ? rd_val : ~held;
  // toggle advances once per ended read
  always @(posedge (ce_n | oe_n)) if (busy && we_n) tog = ~tog;
  // open drain with pull-up: high when released
  assign ready_busy_pin = busy ? 1'b0 : 1'b1;
endmodule

// [tb/fws_host_tb_top.sv]
`timescale 1ns/1ps
module fws_host_tb_top;
  import fws_pkg::*;
  logic clk_sys = 0, rst = 1, clk_en = 1, req_valid = 0;
  fws_req_t req = '0;
  logic req_ready, res_valid, dq_oe, ce_n, oe_n, we_n, ready_busy_pin, busy_seen;
  fws_res_t res;
  logic [19:0] addr;
  logic [7:0] dq_o, dq_dev;
  wire [7:0] dq_bus = dq_oe ? dq_o : dq_dev; // host wins while it drives
  logic [7:0] shadow [logic [19:0]]; // expected array contents
  int n_mismatch = 0, checked = 0;
  localparam logic [19:0] PROT_BASE = 20'hF0000; // protected sector in the model
  integer seed = 32'h97D68E75;
  fws_host i_fws_host (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .req_valid(req_valid),
    .req(req),
    .req_ready(req_ready),
    .res_valid(res_valid),
    .res(res),
    .addr(addr),
    .dq_o(dq_o),
    .dq_oe(dq_oe),
    .dq_i(dq_bus),
    .ce_n(ce_n),
    .oe_n(oe_n),
    .we_n(we_n),
    .ready_busy_pin(ready_busy_pin),
    .busy_seen(busy_seen)
  );
  fws_flash_model #(.PROT_BASE(PROT_BASE)) i_fws_flash_model (
    .addr(addr),
    .dq_in(dq_bus),
    .ce_n(ce_n),
    .oe_n(oe_n),
    .we_n(we_n),
    .dq_out(dq_dev),
    .ready_busy_pin(ready_busy_pin)
  );
  initial forever #5 clk_sys = ~clk_sys;
  // random stalls stretch some strobe phases
  always @(negedge clk_sys) if (!rst) clk_en <= (($random(seed) & 7) != 0);
  task automatic cmp(input string what, input logic [9:0] exp, input logic [9:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // {ok, fail, last} from the shadow array
  function automatic logic [9:0] expect_res(input fws_op_t op, input logic [19:0] a,
                                            input logic [7:0] d);
    logic [7:0] old;
    old = shadow.exists(a) ? shadow[a] : 8'hFF;
    // protected sector: operation ends clean, contents kept
    if (a >= PROT_BASE && op != FWS_OP_CHIP) return {2'b10, old};
    if (op != FWS_OP_PROG) return {2'b10, 8'hFF};
    if ((d & ~old) != 8'h00) return {2'b01, 8'h00};
    return {2'b10, old & d};
  endfunction
  task automatic do_op(input fws_op_t op, input logic [19:0] a, input logic [7:0] d);
    logic [9:0] e;
    int n;
    e = expect_res(op, a, d);
    @(negedge clk_sys);
    req = '{op: op, addr: a, data: d};
    req_valid = 1'b1;
    n = 0;
    // held until the design drops ready on taking it
    while (req_ready === 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    req_valid = 1'b0;
    n = 0;
    while (res_valid !== 1'b1 && !(op == FWS_OP_RESET && req_ready === 1'b1) && n < 12000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    cmp("finished", 10'h000, {9'h000, n >= 12000});
    if (op != FWS_OP_RESET) begin
      cmp("res", e, e[8] ? {res[9:8], 8'h00} : res);
      cmp("busy_seen", 10'h001, {9'h000, busy_seen});
      if (e[9] && op == FWS_OP_PROG) shadow[a] = e[7:0];
      else if (e[9] && (a < PROT_BASE || op == FWS_OP_CHIP)) shadow.delete();
    end
    cmp("ready_pin", 10'h001, {9'h000, ready_busy_pin});
    $display("test op %0d addr %h done", op, a);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // stop a hang far beyond the expected run
  initial begin
    #600000;
    n_mismatch++;
    close_out;
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    do_op(FWS_OP_CHIP, 20'h00000, 8'h00);
    do_op(FWS_OP_PROG, 20'h00100, 8'h5A);
    do_op(FWS_OP_PROG, 20'h00100, 8'hA5);
    do_op(FWS_OP_RESET, 20'h00000, 8'h00);
    do_op(FWS_OP_PROG, 20'h00003, 8'h00);
    do_op(FWS_OP_PROG, PROT_BASE, 8'h00);
    do_op(FWS_OP_SECT, PROT_BASE, 8'h00);
    do_op(FWS_OP_PROG, 20'h00003, 8'h01);
    // small address range so random programs collide and sometimes fail
    for (int i = 0; i < 8; i++) begin
      do_op(FWS_OP_PROG, 20'($random(seed) & 3), 8'($random(seed)));
    end
    do_op(FWS_OP_SECT, 20'h10000, 8'h00);
    do_op(FWS_OP_PROG, 20'h00002, 8'h80);
    close_out;
  end
endmodule
